// ===== rtl/timer8_pkg.sv
/*
  Constants shared by the quad 8-bit timer: register byte offsets, field
  positions, reset values and selector codes.
  Assumes an 8-bit register port with byte addresses.
*/
package timer8_pkg;
  localparam int NCH = 4;
  localparam logic [7:0] CTRL_OFS [NCH] = '{8'h80, 8'h81, 8'h90, 8'h91};
  localparam logic [7:0] CSR_OFS [NCH] = '{8'h82, 8'h83, 8'h92, 8'h93};
  localparam logic [7:0] CONST_A_OFS [NCH] = '{8'h84, 8'h85, 8'h94, 8'h95};
  localparam logic [7:0] CONST_B_OFS [NCH] = '{8'h86, 8'h87, 8'h96, 8'h97};
  localparam logic [7:0] COUNT_OFS [NCH] = '{8'h88, 8'h89, 8'h98, 8'h99};
  localparam logic [7:0] IRQ_STATUS_LO_OFS = 8'hA0;
  localparam logic [7:0] IRQ_STATUS_HI_OFS = 8'hA1;
  localparam logic [7:0] IRQ_MASK_LO_OFS = 8'hA2;
  localparam logic [7:0] IRQ_MASK_HI_OFS = 8'hA3;

  localparam int CTRL_MATCH_B_IE = 7;
  localparam int CTRL_MATCH_A_IE = 6;
  localparam int CTRL_OVF_IE = 5;
  localparam int CTRL_CLR_LSB = 3;
  localparam int CTRL_CKS_LSB = 0;
  localparam int CSR_MATCH_B_FLAG = 7;
  localparam int CSR_MATCH_A_FLAG = 6;
  localparam int CSR_OVF_FLAG = 5;
  localparam int CSR_FUNC_BIT = 4;
  localparam int CSR_OIS_LSB = 2;
  localparam int CSR_OS_LSB = 0;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [7:0] CONST_RESET = 8'hFF;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;

  localparam logic [2:0] CKS_STOP = 3'h0;
  localparam logic [2:0] CKS_DIV8 = 3'h1;
  localparam logic [2:0] CKS_DIV64 = 3'h2;
  localparam logic [2:0] CKS_DIV8192 = 3'h3;
  localparam logic [2:0] CKS_CASCADE = 3'h4;
  localparam logic [2:0] CKS_EXT_FALL = 3'h5;
  localparam logic [2:0] CKS_EXT_RISE = 3'h6;
  localparam logic [2:0] CKS_EXT_BOTH = 3'h7;
  localparam int PRE_W = 13;
  localparam int DIV8_BITS = 3;
  localparam int DIV64_BITS = 6;

  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_MATCH_A = 2'h1;
  localparam logic [1:0] CLR_MATCH_B_CAP = 2'h2;
  localparam logic [1:0] CLR_CAP_ONLY = 2'h3;

  localparam logic [1:0] OUT_KEEP = 2'h0;
  localparam logic [1:0] OUT_LOW = 2'h1;
  localparam logic [1:0] OUT_HIGH = 2'h2;
  localparam logic [1:0] OUT_TOGGLE = 2'h3;

  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage

// ===== rtl/timer_chan_if.sv
/*
  Bundle between the timer top and one counter channel.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface timer_chan_if;
  logic tick;
  logic cap_ev;
  logic cap_mode;
  logic wr_cnt;
  logic wr_a;
  logic wr_b;
  logic [1:0] clr_sel;
  logic [1:0] act_a;
  logic [1:0] act_b;
  logic [7:0] wdata;
  logic [7:0] cnt;
  logic [7:0] cor_a;
  logic [7:0] cor_b;
  logic match_a;
  logic match_b;
  logic ovf;
  logic pin_out;
  modport ctrl (output tick, cap_ev, cap_mode, wr_cnt, wr_a, wr_b, clr_sel, act_a, act_b, wdata,
                input cnt, cor_a, cor_b, match_a, match_b, ovf, pin_out);
  modport chan (input tick, cap_ev, cap_mode, wr_cnt, wr_a, wr_b, clr_sel, act_a, act_b, wdata,
                output cnt, cor_a, cor_b, match_a, match_b, ovf, pin_out);
endinterface

// ===== rtl/timer_channel.sv
/*
  One 8-bit counter channel: counter, two constant registers, compare,
  clearing, capture into constant B and the compare-driven output level.
  Assumes tick and cap_ev are single-cycle pulses in the core clock domain.
*/
`timescale 1ns/1ps
module timer_channel
  import timer8_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  timer_chan_if.chan bus
);
  logic [7:0] cnt_reg;
  logic [7:0] cor_a_reg;
  logic [7:0] cor_b_reg;
  logic match_a_reg;
  logic match_b_reg;
  logic ovf_reg;
  logic out_reg;

  // A match fires on the count edge that leaves the matching value, so
  // clearing on match gives a period of constant plus one.
  wire hit_a = bus.tick && (cnt_reg == cor_a_reg);
  wire hit_b = bus.tick && !bus.cap_mode && (cnt_reg == cor_b_reg);
  wire clr = ((bus.clr_sel == CLR_MATCH_A) && hit_a) ||
             ((bus.clr_sel == CLR_MATCH_B_CAP) && (hit_b || bus.cap_ev)) ||
             ((bus.clr_sel == CLR_CAP_ONLY) && bus.cap_ev);
  wire wrap = bus.tick && (cnt_reg == COUNT_MAX) && !clr;
  wire [1:0] sel_a = hit_a ? bus.act_a : OUT_KEEP;
  wire [1:0] sel_b = (hit_b && !bus.cap_mode) ? bus.act_b : OUT_KEEP;
  wire do_tog = (sel_a == OUT_TOGGLE) || (sel_b == OUT_TOGGLE);
  wire do_set = (sel_a == OUT_HIGH) || (sel_b == OUT_HIGH);
  wire do_low = (sel_a == OUT_LOW) || (sel_b == OUT_LOW);
  wire out_next = do_tog ? !out_reg : do_set ? 1'b1 : do_low ? 1'b0 : out_reg;
  // Clearing beats a software write, and a write beats the increment.
  wire [7:0] cnt_next = clr ? COUNT_RESET : bus.wr_cnt ? bus.wdata :
                        bus.tick ? 8'(cnt_reg + 8'h01) : cnt_reg;
  wire [7:0] cor_a_next = bus.wr_a ? bus.wdata : cor_a_reg;
  // A capture wins over a software write to constant B.
  wire [7:0] cor_b_next = bus.cap_ev ? cnt_reg : bus.wr_b ? bus.wdata : cor_b_reg;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      cnt_reg <= COUNT_RESET;
      cor_a_reg <= CONST_RESET;
      cor_b_reg <= CONST_RESET;
      match_a_reg <= 1'b0;
      match_b_reg <= 1'b0;
      ovf_reg <= 1'b0;
      out_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      cor_a_reg <= cor_a_next;
      cor_b_reg <= cor_b_next;
      match_a_reg <= hit_a;
      match_b_reg <= hit_b || bus.cap_ev;
      ovf_reg <= wrap;
      out_reg <= out_next;
    end
  end

  assign bus.cnt = cnt_reg;
  assign bus.cor_a = cor_a_reg;
  assign bus.cor_b = cor_b_reg;
  assign bus.match_a = match_a_reg;
  assign bus.match_b = match_b_reg;
  assign bus.ovf = ovf_reg;
  assign bus.pin_out = out_reg;
endmodule

// ===== rtl/quad_eight_bit_timer.sv
/*
  Four-channel 8-bit timer in two cascadable groups, with register port,
  prescaler, pin synchronisers, capture, A/D trigger and interrupts.
  Assumes a single 25 MHz core clock; all pins are asynchronous to it.
*/
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module quad_eight_bit_timer
  import timer8_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic ext_clk_in_a_i,
  input wire logic ext_clk_in_b_i,
  input wire logic ext_clk_in_c_i,
  input wire logic ext_clk_in_d_i,
  output logic match_out_pin0_o,
  output logic match_out_pin2_o,
  input wire logic match_out_capture_in_pin1_i,
  output logic match_out_capture_in_pin1_o,
  output logic match_out_capture_in_pin1_oe_n_o,
  input wire logic match_out_capture_in_pin3_i,
  output logic match_out_capture_in_pin3_o,
  output logic match_out_capture_in_pin3_oe_n_o,
  output logic adc_trigger_o,
  output logic [7:0] irq_req_o,
  output logic irq_o
);
  logic [7:0] ctrl_reg [NCH];
  logic [7:0] csr_reg [NCH];
  logic [PRE_W-1:0] pre_reg;
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic [5:0] prev_reg;
  logic [11:0] irq_status_reg;
  logic [11:0] irq_mask_reg;
  logic [7:0] rdata_reg;
  logic adc_reg;
  logic [7:0] pin_out_reg;

  timer_chan_if chb [NCH] ();

  // Prescaler taps each give one pulse per divided period.
  wire p8 = &pre_reg[DIV8_BITS-1:0];
  wire p64 = &pre_reg[DIV64_BITS-1:0];
  wire p8192 = &pre_reg;

  // Bits 3:0 are the external clocks of channels 0..3, bits 5:4 the
  // capture pins of channels 1 and 3.
  wire [5:0] pin_raw = {match_out_capture_in_pin3_i, match_out_capture_in_pin1_i,
                        ext_clk_in_b_i, ext_clk_in_d_i, ext_clk_in_a_i, ext_clk_in_c_i};
  wire [5:0] rise = sync2_reg & ~prev_reg;
  wire [5:0] fall = ~sync2_reg & prev_reg;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      pre_reg <= '0;
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else begin
      pre_reg <= PRE_W'(pre_reg + 1'b1);
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  wire [11:0] ev_all;
  wire [7:0] rd_acc [NCH+1];
  wire [NCH-1:0] req_a;
  wire [NCH-1:0] req_b;
  wire [NCH-1:0] req_v;
  assign rd_acc[0] = 8'h00;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gen_ch
      wire sel_ctrl = addr_i == CTRL_OFS[g];
      wire sel_csr = addr_i == CSR_OFS[g];
      wire sel_a = addr_i == CONST_A_OFS[g];
      wire sel_b = addr_i == CONST_B_OFS[g];
      wire sel_cnt = addr_i == COUNT_OFS[g];
      wire wr_ctrl = wr_i && sel_ctrl;
      wire wr_csr = wr_i && sel_csr;
      wire [2:0] cks = ctrl_reg[g][CTRL_CKS_LSB +: 3];
      wire [1:0] ois = csr_reg[g][CSR_OIS_LSB +: 2];
      wire casc;
      wire cap_pin_ev;
      wire cap_mode;

      if (g % 2 == 0) begin : gen_upper
        // The upper channel counts the lower one's overflow and captures
        // together with it, giving a 16-bit counter and capture.
        assign casc = chb[g+1].ovf;
        assign cap_mode = chb[g+1].cap_mode && (cks == CKS_CASCADE);
        assign cap_pin_ev = chb[g+1].cap_ev && (cks == CKS_CASCADE);
        assign chb[g].act_b = ois;
      end else begin : gen_lower
        wire r = rise[4 + g/2];
        wire f = fall[4 + g/2];
        assign casc = chb[g-1].match_a;
        assign cap_mode = csr_reg[g][CSR_FUNC_BIT];
        assign cap_pin_ev = cap_mode && (((ois == EDGE_RISE) && r) ||
                            ((ois == EDGE_FALL) && f) || ((ois == EDGE_BOTH) && (r || f)));
        assign chb[g].act_b = cap_mode ? OUT_KEEP : ois;
      end

      assign chb[g].tick = (cks == CKS_DIV8) ? p8 :
                           (cks == CKS_DIV64) ? p64 :
                           (cks == CKS_DIV8192) ? p8192 :
                           (cks == CKS_CASCADE) ? casc :
                           (cks == CKS_EXT_FALL) ? fall[g] :
                           (cks == CKS_EXT_RISE) ? rise[g] :
                           (cks == CKS_EXT_BOTH) ? (rise[g] || fall[g]) : 1'b0;
      assign chb[g].cap_ev = cap_pin_ev;
      assign chb[g].cap_mode = cap_mode;
      assign chb[g].clr_sel = ctrl_reg[g][CTRL_CLR_LSB +: 2];
      assign chb[g].act_a = csr_reg[g][CSR_OS_LSB +: 2];
      assign chb[g].wr_cnt = wr_i && sel_cnt;
      assign chb[g].wr_a = wr_i && sel_a;
      assign chb[g].wr_b = wr_i && sel_b;
      assign chb[g].wdata = wdata_i;

      timer_channel u_chan (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .bus(chb[g])
      );

      // Status flags: a new event wins over a clearing write of zero.
      wire [2:0] flag_set = {chb[g].match_b, chb[g].match_a, chb[g].ovf};
      wire [2:0] flag_keep = wr_csr ? wdata_i[7:5] : 3'h7;
      wire [2:0] flag_next = flag_set | (csr_reg[g][7:5] & flag_keep);
      wire [4:0] low_next = wr_csr ? wdata_i[4:0] : csr_reg[g][4:0];

      always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
          ctrl_reg[g] <= CTRL_RESET;
          csr_reg[g] <= CSR_RESET;
        end else begin
          if (wr_ctrl) begin
            ctrl_reg[g] <= wdata_i;
          end
          csr_reg[g] <= {flag_next, low_next};
        end
      end

      assign ev_all[g*3 +: 3] = flag_set;
      assign req_a[g] = csr_reg[g][CSR_MATCH_A_FLAG] && ctrl_reg[g][CTRL_MATCH_A_IE];
      assign req_b[g] = csr_reg[g][CSR_MATCH_B_FLAG] && ctrl_reg[g][CTRL_MATCH_B_IE];
      assign req_v[g] = csr_reg[g][CSR_OVF_FLAG] && ctrl_reg[g][CTRL_OVF_IE];

      wire [7:0] rd_ch = sel_ctrl ? ctrl_reg[g] :
                         sel_csr ? csr_reg[g] :
                         sel_a ? chb[g].cor_a :
                         sel_b ? chb[g].cor_b :
                         sel_cnt ? chb[g].cnt : 8'h00;
      assign rd_acc[g+1] = rd_acc[g] | rd_ch;
    end

    // Per group: upper channel match A and match B own a line each, the
    // lower channel's two matches share one, and both overflows share one.
    for (g = 0; g < 2; g++) begin : gen_vec
      assign irq_req_o[4*g] = req_a[2*g];
      assign irq_req_o[4*g+1] = req_b[2*g];
      assign irq_req_o[4*g+2] = req_a[2*g+1] || req_b[2*g+1];
      assign irq_req_o[4*g+3] = req_v[2*g] || req_v[2*g+1];
    end
  endgenerate

  // Summary interrupt: sticky copies of all twelve events, cleared by
  // writing ones, gated by a mask of the same layout.
  wire wr_st_lo = wr_i && (addr_i == IRQ_STATUS_LO_OFS);
  wire wr_st_hi = wr_i && (addr_i == IRQ_STATUS_HI_OFS);
  wire wr_mk_lo = wr_i && (addr_i == IRQ_MASK_LO_OFS);
  wire wr_mk_hi = wr_i && (addr_i == IRQ_MASK_HI_OFS);
  wire [11:0] w1c = {wr_st_hi ? wdata_i[3:0] : 4'h0, wr_st_lo ? wdata_i : 8'h00};
  wire [11:0] irq_status_next = ev_all | (irq_status_reg & ~w1c);
  wire [11:0] irq_mask_next = {wr_mk_hi ? wdata_i[3:0] : irq_mask_reg[11:8],
                               wr_mk_lo ? wdata_i : irq_mask_reg[7:0]};

  wire [7:0] rd_irq = (addr_i == IRQ_STATUS_LO_OFS) ? irq_status_reg[7:0] :
                      (addr_i == IRQ_STATUS_HI_OFS) ? {4'h0, irq_status_reg[11:8]} :
                      (addr_i == IRQ_MASK_LO_OFS) ? irq_mask_reg[7:0] :
                      (addr_i == IRQ_MASK_HI_OFS) ? {4'h0, irq_mask_reg[11:8]} : 8'h00;
  wire [7:0] rd_mux = rd_acc[NCH] | rd_irq;

  // Channels 0 and 2 carry the trigger enable in their function bit.
  wire adc_next = (csr_reg[0][CSR_FUNC_BIT] && chb[0].match_a) ||
                  (csr_reg[2][CSR_FUNC_BIT] && chb[2].match_a);

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      irq_status_reg <= '0;
      irq_mask_reg <= '0;
      rdata_reg <= 8'h00;
      adc_reg <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
      rdata_reg <= rd_i ? rd_mux : 8'h00;
      adc_reg <= adc_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign adc_trigger_o = adc_reg;
  assign irq_o = |(irq_status_reg & irq_mask_reg);

  // Pin levels already come from the channel output flops.
  assign match_out_pin0_o = chb[0].pin_out;
  assign match_out_pin2_o = chb[2].pin_out;
  assign match_out_capture_in_pin1_o = chb[1].pin_out;
  assign match_out_capture_in_pin3_o = chb[3].pin_out;
  // A pin in capture use is released so the outside can drive it.
  assign match_out_capture_in_pin1_oe_n_o = chb[1].cap_mode;
  assign match_out_capture_in_pin3_oe_n_o = chb[3].cap_mode;
endmodule

// ===== tb/timer_props.sv
/*
  Port-level assertions for the quad 8-bit timer.
  Assumes the single core clock and the active-low synchronous reset of the top module.
*/
`timescale 1ns/1ps
module timer_props (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic match_out_capture_in_pin1_oe_n_o,
  input wire logic match_out_capture_in_pin3_oe_n_o,
  input wire logic adc_trigger_o,
  input wire logic [7:0] irq_req_o,
  input wire logic irq_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  sequence s_wr(a);
    wr_i && addr_i == a;
  endsequence
  sequence s_rd(a);
    rd_i && addr_i == a;
  endsequence
  property p_readback(a);
    s_wr(a) ##1 s_rd(a) |=> rdata_o == $past(wdata_i, 2);
  endproperty
  a_ctrl_read_back: assert property (p_readback(8'h80)) else $error("control byte read back differs");
  a_const_read_back: assert property (p_readback(8'h84)) else $error("constant read back differs");
  a_unmapped_reads_zero: assert property (s_rd(8'hB0) |=> rdata_o == 8'h00) else $error("unmapped read");
  a_rdata_only_after: assert property (rdata_o != 8'h00 |-> $past(rd_i)) else $error("read data out of slot");
  a_reset_quiets_outputs: assert property (disable iff (1'b0) !reset_n_i |=>
    rdata_o == 8'h00 && !irq_o && irq_req_o == 8'h00 && !adc_trigger_o) else $error("reset state");
  a_adc_single_pulse: assert property (adc_trigger_o |=> !adc_trigger_o) else $error("trigger too long");
  a_pin1_dir_write: assert property ($changed(match_out_capture_in_pin1_oe_n_o) && $past(reset_n_i) |->
    $past(wr_i && addr_i == 8'h83)) else $error("pin1 direction moved");
  a_pin3_dir_write: assert property ($changed(match_out_capture_in_pin3_oe_n_o) && $past(reset_n_i) |->
    $past(wr_i && addr_i == 8'h93)) else $error("pin3 direction moved");
  a_request_drop_write: assert property ($past(reset_n_i) && |($past(irq_req_o) & ~irq_req_o) |->
    $past(wr_i)) else $error("request dropped");
  a_irq_drop_write: assert property ($fell(irq_o) && $past(reset_n_i) |-> $past(wr_i))
    else $error("interrupt dropped");
endmodule
bind quad_eight_bit_timer timer_props u_props (.core_clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .match_out_capture_in_pin1_oe_n_o, .match_out_capture_in_pin3_oe_n_o, .adc_trigger_o,
  .irq_req_o, .irq_o);

// ===== tb/timer_pin_model.sv
/*
  Far-side pin model: external count clocks and capture inputs.
  Assumes the core clock; every pin change follows a rising edge.
*/
`timescale 1ns/1ps
module timer_pin_model (
  input wire logic core_clk_i,
  input wire logic pin1_level_i,
  input wire logic pin1_oe_n_i,
  input wire logic pin3_level_i,
  input wire logic pin3_oe_n_i,
  output logic ext_clk_in_a_o,
  output logic ext_clk_in_b_o,
  output logic ext_clk_in_c_o,
  output logic ext_clk_in_d_o,
  output logic pin1_o,
  output logic pin3_o
);
  logic [3:0] clk_by_ch = 4'h0;
  logic drv1 = 1'b0;
  logic drv3 = 1'b0;
  assign ext_clk_in_c_o = clk_by_ch[0];
  assign ext_clk_in_a_o = clk_by_ch[1];
  assign ext_clk_in_d_o = clk_by_ch[2];
  assign ext_clk_in_b_o = clk_by_ch[3];
  // The device owns the wire while its enable is low, so it must see its own level back.
  assign pin1_o = pin1_oe_n_i ? drv1 : pin1_level_i;
  assign pin3_o = pin3_oe_n_i ? drv3 : pin3_level_i;
  // Six cycles per phase leave room for the two-flop synchroniser and edge detect.
  task automatic pulse(input int ch, input int n);
    repeat (n) begin
      @(posedge core_clk_i);
      clk_by_ch[ch] <= 1'b1;
      repeat (6) @(posedge core_clk_i);
      clk_by_ch[ch] <= 1'b0;
      repeat (6) @(posedge core_clk_i);
    end
  endtask
  task automatic capture_rise();
    // Both two-way pins rise together so each capture channel sees one edge.
    @(posedge core_clk_i);
    drv1 <= 1'b1;
    drv3 <= 1'b1;
    repeat (8) @(posedge core_clk_i);
  endtask
endmodule

// ===== tb/test_quad_eight_bit_timer.sv
/*
  Self-checking bench for the quad 8-bit timer.
  Assumes the pin model for the far side and the checker bound to the top module.
*/
`timescale 1ns/1ps
module test_quad_eight_bit_timer;
  import timer8_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o, irq_req_o;
  logic ext_clk_in_a_i, ext_clk_in_b_i, ext_clk_in_c_i, ext_clk_in_d_i, match_out_pin0_o, match_out_pin2_o;
  logic match_out_capture_in_pin1_i, match_out_capture_in_pin1_o, match_out_capture_in_pin1_oe_n_o;
  logic match_out_capture_in_pin3_i, match_out_capture_in_pin3_o, match_out_capture_in_pin3_oe_n_o;
  logic adc_trigger_o, irq_o;
  int errors = 0;
  int comparisons = 0;
  always #20 core_clk_i = ~core_clk_i;
  quad_eight_bit_timer u_dut (.core_clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .ext_clk_in_a_i, .ext_clk_in_b_i, .ext_clk_in_c_i, .ext_clk_in_d_i, .match_out_pin0_o, .match_out_pin2_o,
    .match_out_capture_in_pin1_i, .match_out_capture_in_pin1_o, .match_out_capture_in_pin1_oe_n_o,
    .match_out_capture_in_pin3_i, .match_out_capture_in_pin3_o, .match_out_capture_in_pin3_oe_n_o,
    .adc_trigger_o, .irq_req_o, .irq_o);
  timer_pin_model u_far (.core_clk_i, .pin1_level_i(match_out_capture_in_pin1_o),
    .pin1_oe_n_i(match_out_capture_in_pin1_oe_n_o), .pin3_level_i(match_out_capture_in_pin3_o),
    .pin3_oe_n_i(match_out_capture_in_pin3_oe_n_o), .ext_clk_in_a_o(ext_clk_in_a_i),
    .ext_clk_in_b_o(ext_clk_in_b_i), .ext_clk_in_c_o(ext_clk_in_c_i), .ext_clk_in_d_o(ext_clk_in_d_i),
    .pin1_o(match_out_capture_in_pin1_i), .pin3_o(match_out_capture_in_pin3_i));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    // Returning just past the edge lets callers look at state that the write has already updated.
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 check(16'(rdata_o), 16'(exp));
  endtask
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    wr_i <= 1'b0;
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 check(16'(rdata_o), 16'(d));
  endtask
  task automatic t_reset();
    for (int c = 0; c < NCH; c++) begin
      rdc(CTRL_OFS[c], CTRL_RESET);
      rdc(CSR_OFS[c], CSR_RESET);
      rdc(CONST_A_OFS[c], CONST_RESET);
      rdc(CONST_B_OFS[c], CONST_RESET);
      rdc(COUNT_OFS[c], COUNT_RESET);
    end
  endtask
  task automatic t_bus();
    wr_rd(CTRL_OFS[0], 8'hF8);
    wr_rd(CONST_A_OFS[0], 8'h3C);
    wr(8'hB0, 8'h55);
    rdc(8'hB0, 8'h00);
    wr(CTRL_OFS[0], 8'h00);
    wr(CONST_A_OFS[0], 8'h00);
    wr(CONST_B_OFS[0], 8'h00);
    wr(CSR_OFS[0], 8'h13);
  endtask
  // Trigger pulses mark each match A of channel 0, so their spacing is the counter period.
  task automatic wait_adc(output int n);
    n = 0;
    do begin
      @(posedge core_clk_i);
      #1;
      n++;
    end while (adc_trigger_o !== 1'b1 && n < 9000);
  endtask
  task automatic t_period(input logic [7:0] ctl, input int per, input logic [7:0] csr_exp);
    int n;
    logic lvl;
    wr(CTRL_OFS[0], ctl);
    wait_adc(n);
    lvl = match_out_pin0_o;
    wait_adc(n);
    check(16'(n), 16'(per));
    check(16'(match_out_pin0_o), 16'(!lvl));
    wr(CTRL_OFS[0], 8'h00);
    rdc(CSR_OFS[0], csr_exp);
    wr(CSR_OFS[0], 8'h13);
  endtask
  task automatic t_ext();
    logic [7:0] code [NCH] = '{8'h05, 8'h06, 8'h07, 8'h06};
    logic [7:0] cnt [NCH] = '{8'h03, 8'h03, 8'h06, 8'h03};
    for (int c = 0; c < NCH; c++) begin
      wr(COUNT_OFS[c], 8'h00);
      wr(CTRL_OFS[c], code[c]);
      u_far.pulse(c, 3);
      wr(CTRL_OFS[c], 8'h00);
      rdc(COUNT_OFS[c], cnt[c]);
    end
  endtask
  task automatic t_cascade();
    wr(COUNT_OFS[0], 8'h00);
    wr(COUNT_OFS[1], 8'hFE);
    wr(CTRL_OFS[0], 8'h04);
    wr(CTRL_OFS[1], 8'h06);
    u_far.pulse(1, 2);
    rdc(COUNT_OFS[1], 8'h00);
    rdc(COUNT_OFS[0], 8'h01);
    rdc(COUNT_OFS[2], 8'h06);
    wr(CTRL_OFS[0], 8'h00);
    wr(CTRL_OFS[1], 8'h00);
    wr(CONST_A_OFS[2], 8'h00);
    wr(COUNT_OFS[2], 8'h00);
    wr(COUNT_OFS[3], 8'h00);
    wr(CTRL_OFS[3], 8'h04);
    wr(CSR_OFS[2], 8'h03);
    wr(CTRL_OFS[2], 8'h0E);
    u_far.pulse(2, 3);
    rdc(COUNT_OFS[3], 8'h03);
    check(16'(match_out_pin2_o), 16'h0001);
    wr(CTRL_OFS[3], 8'h00);
  endtask
  task automatic t_overflow();
    wr(CSR_OFS[2], 8'h00);
    wr(COUNT_OFS[2], 8'hFF);
    wr(CTRL_OFS[2], 8'h26);
    u_far.pulse(2, 1);
    wr(CTRL_OFS[2], 8'h20);
    check(16'(irq_req_o[7]), 16'h0001);
    wr(IRQ_MASK_LO_OFS, 8'h40);
    repeat (2) @(posedge core_clk_i);
    check(16'(irq_o), 16'h0001);
    wr(CSR_OFS[2], 8'hE0);
    // Constant B still holds all ones, so the wrap tick also matches B.
    rdc(CSR_OFS[2], 8'hA0);
    wr(CSR_OFS[2], 8'h00);
    check(16'(irq_req_o[7]), 16'h0000);
    wr(IRQ_STATUS_LO_OFS, 8'h40);
    repeat (2) @(posedge core_clk_i);
    check(16'(irq_o), 16'h0000);
  endtask
  task automatic t_capture();
    wr(COUNT_OFS[1], 8'h2A);
    wr(CSR_OFS[1], 8'h18);
    wr(CSR_OFS[3], 8'h18);
    check({match_out_capture_in_pin1_oe_n_o, match_out_capture_in_pin3_oe_n_o}, 16'h0003);
    wr(COUNT_OFS[2], 8'h5A);
    wr(CTRL_OFS[2], 8'h04);
    u_far.capture_rise();
    rdc(CONST_B_OFS[1], 8'h2A);
    rdc(CSR_OFS[1], 8'h98);
    rdc(CONST_B_OFS[3], 8'h03);
    rdc(CSR_OFS[3], 8'h98);
    rdc(CONST_B_OFS[2], 8'h5A);
    wr(CSR_OFS[1], 8'h00);
    wr(CSR_OFS[3], 8'h00);
    check({match_out_capture_in_pin1_oe_n_o, match_out_capture_in_pin3_oe_n_o}, 16'h0000);
  endtask
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_bus();
    t_period(8'h09, 8, 8'hD3);
    t_period(8'h0A, 64, 8'hD3);
    t_period(8'h0B, 8192, 8'hD3);
    t_period(8'h11, 8, 8'hD3);
    t_period(8'h01, 2048, 8'hF3);
    t_period(8'h19, 2048, 8'hF3);
    t_ext();
    t_cascade();
    t_overflow();
    t_capture();
    results();
  end
  // The longest scenario needs about two prescaler periods of 8192 cycles each.
  initial begin
    repeat (80000) @(posedge core_clk_i);
    errors++;
    results();
  end
endmodule
